//--- obcd_option_store.sv
/*
 non-volatile store of the two option bytes, read data straight from
 registers. assumes the top sequences erase, write and init exclusively.
*/
`timescale 1ns/1ns
module obcd_option_store
    import obcd_pkg::*;
(
    input  wire logic       clk_in,          // system clock
    input  wire logic       init_in,         // factory blank load
    input  wire logic       erase_in,        // erase both bytes to ff
    input  wire logic       wr_en_in,        // program one byte
    input  wire logic       wr_idx_in,       // byte index
    input  wire logic [7:0] wr_data_in,      // byte value
    output logic      [7:0] prot_byte_out,   // protect byte
    output logic      [7:0] clksup_byte_out  // clock byte
);
    // contents survive reset on purpose: this models flash cells
    logic [7:0] mem_ff [2];  // cell array

    // one write source per cycle, init has priority
    always_ff @(posedge clk_in)
    begin
        if (init_in)
        begin
            mem_ff[IDX_PROT]   <= PROT_RESET;
            mem_ff[IDX_CLKSUP] <= CLKSUP_RESET;
        end
        else if (erase_in)
        begin
            mem_ff[IDX_PROT]   <= ERASED_BYTE;
            mem_ff[IDX_CLKSUP] <= ERASED_BYTE;
        end
        else if (wr_en_in)
        begin
            mem_ff[wr_idx_in] <= wr_data_in;
        end
    end

    // registered read of both cells
    always_ff @(posedge clk_in)
    begin
        prot_byte_out   <= mem_ff[IDX_PROT];
        clksup_byte_out <= mem_ff[IDX_CLKSUP];
    end

endmodule : obcd_option_store

//--- obcd_pkg.sv
/*
 package of the option byte configuration decoder: field positions, reset
 values, enumerations, carrier structs and the decode function.
 assumes one 50 MHz clock and a synchronous active-high reset.
*/
// What this block does
// - clock byte bits 7:6 select startup clock
// - clock byte bits 3:2 select supervisor threshold
// - watchdog type 0 runs always, 1 software start
// - halt bit 1 resets on halt if watchdog
// - readout protect blocks external read and write
// - option erase under readout protect erases memory first
// - write protect forever refuses memory and bit changes
// - sector bit selects half or one kilobyte
// - option bytes accessed only in programming mode
// - blank program memory holds erased ff bytes
// - unprogrammed default selects internal rc clock
package obcd_pkg;

    localparam int         OPT_W         = 8;      // option byte width
    localparam logic [7:0] PROT_RESET    = 8'hf0;  // protect byte default
    localparam logic [7:0] CLKSUP_RESET  = 8'h2f;  // clock byte default, rc clock
    localparam logic [7:0] ERASED_BYTE   = 8'hff;  // erased flash value
    localparam logic       IDX_PROT      = 1'b0;   // protect byte index
    localparam logic       IDX_CLKSUP    = 1'b1;   // clock byte index
    // clock byte field positions
    localparam int         CLK_SEL_LO    = 6;
    localparam int         RSV_ONE_POS   = 5;
    localparam int         RSV_ZERO_POS  = 4;
    localparam int         SUP_LO        = 2;
    localparam int         WDG_TYPE_POS  = 1;
    localparam int         HALT_RST_POS  = 0;
    // protect byte field positions
    localparam int         RSV_HI_LO     = 4;
    localparam int         RSV3_POS      = 3;
    localparam int         SECTOR_POS    = 2;
    localparam int         ROP_POS       = 1;
    localparam int         WP_POS        = 0;
    // sector 0 sizes in bytes
    localparam int         SECTOR_SMALL  = 512;
    localparam int         SECTOR_LARGE  = 1024;

    typedef enum logic [1:0] {
        CLK_INT_RC    = 2'h0,
        CLK_WAKEUP_RC = 2'h1,
        CLK_RESERVED  = 2'h2,
        CLK_EXT_PIN   = 2'h3
    } obcd_clk_e;

    typedef enum logic [1:0] {
        SUP_LOWEST  = 2'h0,
        SUP_MEDIUM  = 2'h1,
        SUP_HIGHEST = 2'h2,
        SUP_OFF     = 2'h3
    } obcd_sup_e;

    typedef enum logic [2:0] {
        OP_OPT_READ  = 3'h0,
        OP_OPT_WRITE = 3'h1,
        OP_OPT_ERASE = 3'h2,
        OP_MEM_ERASE = 3'h3,
        OP_MEM_WRITE = 3'h4,
        OP_MEM_READ  = 3'h5
    } obcd_op_e;

    // gray codes along idle, erase, wait, clear
    typedef enum logic [1:0] {
        ST_IDLE      = 2'h0,
        ST_MEM_ERASE = 2'h1,
        ST_WAIT_MEM  = 2'h3,
        ST_OPT_CLEAR = 2'h2
    } obcd_state_e;

    typedef struct packed {
        obcd_clk_e startup_clock_select;
        logic      clock_reserved;
        obcd_sup_e supervisor_threshold_select;
        logic      supervisor_on;
        logic      watchdog_type_select;
        logic      watchdog_halt_reset;
        logic      first_sector_size;
        logic      readout_protect;
        logic      permanent_write_protect;
        logic      reserved_bits_bad;
    } obcd_cfg_s;

    typedef struct packed {
        obcd_op_e   op;
        logic       idx;
        logic [7:0] data;
    } obcd_req_s;

    // decode both option bytes into settings
    function automatic obcd_cfg_s obcd_decode(input logic [7:0] prot, input logic [7:0] clks);
        obcd_cfg_s c;
        c.startup_clock_select        = obcd_clk_e'(clks[CLK_SEL_LO +: 2]);
        c.clock_reserved              = (clks[CLK_SEL_LO +: 2] == CLK_RESERVED);
        c.supervisor_threshold_select = obcd_sup_e'(clks[SUP_LO +: 2]);
        c.supervisor_on               = (clks[SUP_LO +: 2] != SUP_OFF);
        c.watchdog_type_select        = clks[WDG_TYPE_POS];
        c.watchdog_halt_reset         = clks[HALT_RST_POS];
        c.first_sector_size           = prot[SECTOR_POS];
        c.readout_protect             = prot[ROP_POS];
        c.permanent_write_protect     = prot[WP_POS];
        // flags a tool that broke the reserved pattern
        c.reserved_bits_bad = !clks[RSV_ONE_POS] || clks[RSV_ZERO_POS]
                              || (prot[RSV_HI_LO +: 4] != 4'hf) || prot[RSV3_POS];
        return c;
    endfunction : obcd_decode

endpackage : obcd_pkg

//--- obcd_prog_tool.sv
/*
 model of the programming tool and memory controller facing obcd_top.
 assumes inputs sampled at negedge, design registers change at posedge.
*/
`timescale 1ns/1ns
module obcd_prog_tool
    import obcd_pkg::*;
(
    input  wire logic       clk_in,             // system clock
    input  wire logic       resp_valid_in,      // answer strobe
    input  wire logic       resp_ok_in,         // grant flag
    input  wire logic [7:0] resp_data_in,       // read data
    input  wire logic       mem_erase_in,       // erase command
    output obcd_req_s       req_out,            // request word
    output logic            req_valid_out,      // request strobe
    output logic            mem_erase_done_out  // erase finished
);
    int erase_delay = 0;  // cycles the memory takes, 0 prompt

    initial
    begin
        req_out            = '0;
        req_valid_out      = 1'b0;
        mem_erase_done_out = 1'b0;
    end

    // memory controller: holds done as a level, so an early finish is not lost
    initial
    begin
        int n;
        forever
        begin
            @(negedge clk_in);
            if (mem_erase_in === 1'b1)
            begin
                repeat (erase_delay + 1) @(negedge clk_in);
                mem_erase_done_out = 1'b1;
                n = 0;
                while (resp_valid_in !== 1'b1 && n < 100)
                begin
                    @(negedge clk_in);
                    n++;
                end
                mem_erase_done_out = 1'b0;
            end
        end
    end

    // one request, strobe for one cycle, then wait for the answer
    task automatic tool_req(input logic [2:0] op, input logic idx, input logic [7:0] data,
                            output logic ok, output logic [7:0] rdata);
        int n;
        n = 0;
        @(negedge clk_in);
        req_out.op    = obcd_op_e'(op);
        req_out.idx   = idx;
        req_out.data  = data;
        req_valid_out = 1'b1;
        @(negedge clk_in);
        req_valid_out = 1'b0;
        // released lines do not keep the old value
        req_out = obcd_req_s'(~req_out);
        while (resp_valid_in !== 1'b1 && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        // no answer reads as unknown
        ok    = (resp_valid_in === 1'b1) ? resp_ok_in : 1'bx;
        rdata = (resp_valid_in === 1'b1) ? resp_data_in : 8'hxx;
    endtask : tool_req
endmodule : obcd_prog_tool

//--- obcd_top.sv
/*
 option byte configuration decoder: option store access from the
 programming tool, protection checks, erase sequencing and latched
 settings. assumes requests and memory handshakes on clk_in, and a
 programming mode strap that arrives asynchronously on a pin.
*/
`timescale 1ns/1ns
module obcd_top
    import obcd_pkg::*;
(
    input  wire logic                clk_in,               // 50 MHz clock
    input  wire logic                reset_in,             // sync reset, high
    input  wire logic                nvm_init_in,          // blank part load
    input  wire logic                prog_mode_pin_in,     // async programming pin
    input  wire logic                req_valid_in,         // tool request strobe
    input  wire obcd_pkg::obcd_req_s req_in,               // tool request
    input  wire logic                mem_erase_done_in,    // memory erase finished
    input  wire logic                watchdog_type_select_enable_in,     // software starts watchdog
    input  wire logic                halt_entry_in,        // cpu enters halt
    output obcd_pkg::obcd_cfg_s      config_out,           // latched settings
    output logic                     busy_out,             // sequence running
    output logic                     resp_valid_out,       // answer strobe
    output logic                     resp_ok_out,          // request granted
    output logic               [7:0] resp_data_out,        // option read data
    output logic                     mem_erase_out,        // full memory erase
    output logic                     mem_read_allow_out,   // external read allowed
    output logic                     mem_write_allow_out,  // memory write allowed
    output logic                     watchdog_enable_out,  // watchdog running
    output logic                     halt_reset_out        // reset from halt
);
    import obcd_pkg::*;

    logic        sync1_ff, sync2_ff, sync3_ff;  // pin synchroniser
    logic        prog_mode_ff;                  // filtered mode
    logic [7:0]  prot_byte, clksup_byte;        // store contents
    obcd_state_e state_ff, nxt_state;           // erase sequencer
    logic        chain_opt_ff, nxt_chain_opt;   // option erase follows
    logic        take, ok, long_op;             // request decode
    logic        store_wr, store_erase;         // store strobes
    logic        rop_now, wp_now;               // live protection
    obcd_cfg_s   config_ff;
    logic        busy_ff, resp_valid_ff, resp_ok_ff, mem_erase_ff;
    logic        rd_allow_ff, wr_allow_ff, wdg_en_ff, halt_rst_ff;
    logic [7:0]  resp_data_ff;

    assign rop_now = prot_byte[ROP_POS];
    assign wp_now  = prot_byte[WP_POS];

    // three stages; the change counts once stages two and three agree
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sync1_ff     <= 1'b0;
            sync2_ff     <= 1'b0;
            sync3_ff     <= 1'b0;
            prog_mode_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= prog_mode_pin_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff)
                prog_mode_ff <= sync3_ff;
        end
    end

    // grant or refuse a request against mode and protection
    always_comb
    begin
        take = req_valid_in && (state_ff == ST_IDLE);
        ok   = 1'b0;
        case (req_in.op)
            OP_OPT_READ:  ok = prog_mode_ff;
            OP_OPT_WRITE: ok = prog_mode_ff && !(wp_now &&
                               req_in.idx == IDX_PROT && !req_in.data[WP_POS]);
            OP_OPT_ERASE: ok = prog_mode_ff && !wp_now;
            OP_MEM_ERASE: ok = !wp_now;
            OP_MEM_WRITE: ok = !wp_now && !rop_now;
            OP_MEM_READ:  ok = !rop_now;
            default:      ok = 1'b0;                                // unknown op refused
        endcase
        // memory erase, or option erase that must wipe memory first
        long_op = ok && ((req_in.op == OP_MEM_ERASE) ||
                         (req_in.op == OP_OPT_ERASE && rop_now));
    end

    // sequencer next state
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_chain_opt = chain_opt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (take && long_op)
                begin
                    nxt_state     = ST_MEM_ERASE;
                    nxt_chain_opt = (req_in.op == OP_OPT_ERASE);
                end
                else if (take && ok && req_in.op == OP_OPT_ERASE)
                    nxt_state = ST_OPT_CLEAR;
            end
            ST_MEM_ERASE: nxt_state = ST_WAIT_MEM;
            ST_WAIT_MEM:
            begin
                // options stay intact until memory is gone
                if (mem_erase_done_in)
                    nxt_state = chain_opt_ff ? ST_OPT_CLEAR : ST_IDLE;
            end
            ST_OPT_CLEAR: nxt_state = ST_IDLE;
            default:      nxt_state = ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_ff     <= ST_IDLE;
            chain_opt_ff <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            chain_opt_ff <= nxt_chain_opt;
        end
    end

    // a granted option write taken in ST_IDLE drives the store write path
    assign store_wr    = take && ok && (req_in.op == OP_OPT_WRITE);
    assign store_erase = (state_ff == ST_OPT_CLEAR);

    obcd_option_store u_store (
        .clk_in          (clk_in),
        .init_in         (nvm_init_in),
        .erase_in        (store_erase),
        .wr_en_in        (store_wr),
        .wr_idx_in       (req_in.idx),
        .wr_data_in      (req_in.data),
        .prot_byte_out   (prot_byte),
        .clksup_byte_out (clksup_byte)
    );

    // answer one cycle after a short request or at sequence end
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            resp_valid_ff <= 1'b0;
            resp_ok_ff    <= 1'b0;
            resp_data_ff  <= 8'h00;
        end
        else
        begin
            resp_valid_ff <= 1'b0;
            if (take && !long_op && !(ok && req_in.op == OP_OPT_ERASE))
            begin
                resp_valid_ff <= 1'b1;
                resp_ok_ff    <= ok;
                resp_data_ff  <= (ok && req_in.op == OP_OPT_READ) ?
                                 ((req_in.idx == IDX_PROT) ? prot_byte : clksup_byte) : 8'h00;
            end
            else if (store_erase || (state_ff == ST_WAIT_MEM && mem_erase_done_in
                                     && !chain_opt_ff))
            begin
                resp_valid_ff <= 1'b1;
                resp_ok_ff    <= 1'b1;
                resp_data_ff  <= 8'h00;
            end
        end
    end

    // erase pulse and busy follow the next state
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mem_erase_ff <= 1'b0;
            busy_ff      <= 1'b0;
        end
        else
        begin
            mem_erase_ff <= (nxt_state == ST_MEM_ERASE);
            busy_ff      <= (nxt_state != ST_IDLE);
        end
    end

    // live protection levels for the memory controller
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            rd_allow_ff <= 1'b0;
            wr_allow_ff <= 1'b0;
        end
        else
        begin
            rd_allow_ff <= !rop_now;
            wr_allow_ff <= !rop_now && !wp_now;
        end
    end

    // settings follow the store only while reset is held
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            config_ff <= obcd_decode(prot_byte, clksup_byte);
    end

    // hardware type runs from reset; software type is sticky once started
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            wdg_en_ff <= 1'b0;
        else
            wdg_en_ff <= !config_ff.watchdog_type_select || wdg_en_ff || watchdog_type_select_enable_in;
    end

    // halt entry with active watchdog and halt bit set resets
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            halt_rst_ff <= 1'b0;
        else
            halt_rst_ff <= halt_entry_in && config_ff.watchdog_halt_reset && wdg_en_ff;
    end

    assign config_out          = config_ff;
    assign busy_out            = busy_ff;
    assign resp_valid_out      = resp_valid_ff;
    assign resp_ok_out         = resp_ok_ff;
    assign resp_data_out       = resp_data_ff;
    assign mem_erase_out       = mem_erase_ff;
    assign mem_read_allow_out  = rd_allow_ff;
    assign mem_write_allow_out = wr_allow_ff;
    assign watchdog_enable_out = wdg_en_ff;
    assign halt_reset_out      = halt_rst_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    clock_decode_a: assert property ($fell(reset_in) |->
        config_ff.startup_clock_select == obcd_clk_e'($past(clksup_byte[7:6])))
        else $error("startup clock not decoded from byte");
    sup_decode_a: assert property ($fell(reset_in) |->
        config_ff.supervisor_on == ($past(clksup_byte[3:2]) != 2'h3))
        else $error("supervisor enable wrong");
    wdg_type_a: assert property (!config_ff.watchdog_type_select |=> wdg_en_ff)
        else $error("hardware watchdog not running");
    halt_reset_a: assert property (halt_entry_in && wdg_en_ff |=>
        halt_rst_ff == $past(config_ff.watchdog_halt_reset))
        else $error("halt reset mismatch");
    readout_block_a: assert property (take && rop_now && req_in.op == OP_MEM_READ |=>
        resp_valid_ff && !resp_ok_ff)
        else $error("protected readout granted");
    erase_order_a: assert property (take && ok && rop_now && req_in.op == OP_OPT_ERASE |=>
        mem_erase_ff ##1 !store_erase)
        else $error("options erased before memory");
    erase_after_mem_a: assert property (store_erase && rop_now |->
        $past(state_ff) == ST_WAIT_MEM && $past(mem_erase_done_in))
        else $error("options cleared without memory erase");
    wp_refuse_a: assert property (take && wp_now && (req_in.op == OP_MEM_ERASE ||
        req_in.op == OP_MEM_WRITE) |=> resp_valid_ff && !resp_ok_ff && !mem_erase_ff)
        else $error("write protect bypassed");
    sector_decode_a: assert property ($fell(reset_in) |->
        config_ff.first_sector_size == $past(prot_byte[SECTOR_POS]))
        else $error("sector size wrong");
    mode_gate_a: assert property (!prog_mode_ff |-> !store_wr)
        else $error("option write outside programming mode");
    cfg_hold_a: assert property (!$fell(reset_in) |-> $stable(config_ff))
        else $error("settings changed after reset");

    chain_erase_c: cover property (store_erase && chain_opt_ff);
    opt_read_c:    cover property (resp_valid_ff && resp_ok_ff && resp_data_ff != 8'h00);
    halt_rst_c:    cover property (halt_rst_ff);

endmodule : obcd_top

//--- tb_obcd_top.sv
/*
 self-checking bench for obcd_top: option access, decode, protection.
 assumes the tool model above and a 50 MHz clock.
*/
`timescale 1ns/1ns
module tb_obcd_top;
    import obcd_pkg::*;
    logic       clk_in, reset_in, nvm_init_in, prog_mode_pin_in;
    logic       req_valid_in, mem_erase_done_in, watchdog_type_select_enable_in, halt_entry_in;
    obcd_req_s  req_in;
    obcd_cfg_s  config_out, prev;
    logic       busy_out, resp_valid_out, resp_ok_out, mem_erase_out;
    logic [7:0] resp_data_out, d, v;
    logic       mem_read_allow_out, mem_write_allow_out, watchdog_enable_out, halt_reset_out;
    logic       ok;
    logic [1:0] k;
    int         mismatches = 0, check_count = 0, erase_seen = 0, cnt, busy_seen = 0, bcnt;

    obcd_top obcd_top_i (.clk_in(clk_in), .reset_in(reset_in), .nvm_init_in(nvm_init_in),
        .prog_mode_pin_in(prog_mode_pin_in), .req_valid_in(req_valid_in), .req_in(req_in),
        .mem_erase_done_in(mem_erase_done_in), .watchdog_type_select_enable_in(watchdog_type_select_enable_in),
        .halt_entry_in(halt_entry_in), .config_out(config_out), .busy_out(busy_out),
        .resp_valid_out(resp_valid_out), .resp_ok_out(resp_ok_out),
        .resp_data_out(resp_data_out), .mem_erase_out(mem_erase_out),
        .mem_read_allow_out(mem_read_allow_out), .mem_write_allow_out(mem_write_allow_out),
        .watchdog_enable_out(watchdog_enable_out), .halt_reset_out(halt_reset_out));

    obcd_prog_tool obcd_prog_tool_i (.clk_in(clk_in), .resp_valid_in(resp_valid_out),
        .resp_ok_in(resp_ok_out), .resp_data_in(resp_data_out), .mem_erase_in(mem_erase_out),
        .req_out(req_in), .req_valid_out(req_valid_in), .mem_erase_done_out(mem_erase_done_in));

    // 20 ns clock
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // counts full memory erase pulses and busy cycles
    always @(negedge clk_in)
    begin
        if (mem_erase_out === 1'b1)
            erase_seen++;
        if (busy_out === 1'b1)
            busy_seen++;
    end

    task automatic check_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", n, e, g);
        end
    endtask : check_bit

    task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : check_byte

    task automatic check_cfg(input string n, input obcd_cfg_s e, input obcd_cfg_s g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : check_cfg

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // reset held n cycles; init released 3 edges before reset, then sync settles
    task automatic do_reset(input logic init, input int n);
        @(negedge clk_in);
        reset_in    = 1'b1;
        nvm_init_in = init;
        repeat (n - 3) @(negedge clk_in);
        nvm_init_in = 1'b0;
        repeat (3) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask : do_reset

    // decoded clock byte fields
    task automatic check_fields(input logic [1:0] s, input logic [1:0] p, input logic w,
                                input logic h);
        check_byte("clock_sel", {6'h0, s}, {6'h0, config_out.startup_clock_select});
        check_bit("clock_rsv", s == 2'h2, config_out.clock_reserved);
        check_byte("sup_sel", {6'h0, p}, {6'h0, config_out.supervisor_threshold_select});
        check_bit("sup_on", p != 2'h3, config_out.supervisor_on);
        check_bit("wdg_type", w, config_out.watchdog_type_select);
        check_bit("halt_bit", h, config_out.watchdog_halt_reset);
    endtask : check_fields

    // halt entry pulse, reset expected one cycle later or not at all
    task automatic halt_pulse(input logic e);
        @(negedge clk_in);
        halt_entry_in = 1'b1;
        @(negedge clk_in);
        halt_entry_in = 1'b0;
        check_bit("halt_rst", e, halt_reset_out);
    endtask : halt_pulse

    // hang guard, tests take well under 2000 cycles
    initial
    begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        reset_in = 1'b1;
        nvm_init_in = 1'b1;
        prog_mode_pin_in = 1'b0;
        watchdog_type_select_enable_in = 1'b0;
        halt_entry_in = 1'b0;
        do_reset(1'b1, 20);
        check_fields(2'h0, 2'h3, 1'b1, 1'b1);
        check_bit("wdg_en", 1'b0, watchdog_enable_out);
        check_bit("rd_allow", 1'b1, mem_read_allow_out);
        check_bit("wr_allow", 1'b1, mem_write_allow_out);
        obcd_prog_tool_i.tool_req(3'h0, 1'b0, 8'h00, ok, d);
        check_bit("opt_rd_ok", 1'b0, ok);
        prog_mode_pin_in = 1'b1;
        repeat (8) @(negedge clk_in);
        obcd_prog_tool_i.tool_req(3'h0, 1'b0, 8'h00, ok, d);
        check_byte("prot_byte", 8'hf0, d);
        obcd_prog_tool_i.tool_req(3'h0, 1'b1, 8'h00, ok, d);
        check_byte("clk_byte", 8'h2f, d);
        // every clock, supervisor, watchdog and halt code
        for (int i = 0; i < 4; i++)
        begin
            k = 2'(i);
            v = {k, 2'b10, ~k, k[0], k[1]};
            prev = config_out;
            obcd_prog_tool_i.tool_req(3'h1, 1'b1, v, ok, d);
            check_bit("opt_wr_ok", 1'b1, ok);
            obcd_prog_tool_i.tool_req(3'h0, 1'b1, 8'h00, ok, d);
            check_byte("clk_byte", v, d);
            check_cfg("cfg_hold", prev, config_out);
            do_reset(1'b0, 4);
            check_fields(k, ~k, k[0], k[1]);
            check_bit("wdg_en", ~k[0], watchdog_enable_out);
            halt_pulse(~k[0] & k[1]);
            if (k[0])
            begin
                @(negedge clk_in);
                watchdog_type_select_enable_in = 1'b1;
                @(negedge clk_in);
                watchdog_type_select_enable_in = 1'b0;
                check_bit("wdg_en", 1'b1, watchdog_enable_out);
                halt_pulse(k[1]);
            end
        end
        obcd_prog_tool_i.tool_req(3'h1, 1'b0, 8'hf4, ok, d);
        do_reset(1'b0, 4);
        check_bit("sector", 1'b1, config_out.first_sector_size);
        obcd_prog_tool_i.tool_req(3'h5, 1'b0, 8'h00, ok, d);
        check_bit("mem_rd_ok", 1'b1, ok);
        obcd_prog_tool_i.tool_req(3'h4, 1'b0, 8'h00, ok, d);
        check_bit("mem_wr_ok", 1'b1, ok);
        for (int op = 6; op < 8; op++)
        begin
            obcd_prog_tool_i.tool_req(3'(op), 1'b0, 8'h00, ok, d);
            check_bit("bad_op_ok", 1'b0, ok);
        end
        cnt = erase_seen;
        obcd_prog_tool_i.tool_req(3'h3, 1'b0, 8'h00, ok, d);
        check_bit("mem_er_ok", 1'b1, ok);
        check_byte("erase_cnt", 8'(cnt + 1), 8'(erase_seen));
        obcd_prog_tool_i.tool_req(3'h1, 1'b0, 8'hf6, ok, d);
        repeat (2) @(negedge clk_in);
        check_bit("rd_allow", 1'b0, mem_read_allow_out);
        check_bit("wr_allow", 1'b0, mem_write_allow_out);
        obcd_prog_tool_i.tool_req(3'h5, 1'b0, 8'h00, ok, d);
        check_bit("mem_rd_ok", 1'b0, ok);
        obcd_prog_tool_i.tool_req(3'h4, 1'b0, 8'h00, ok, d);
        check_bit("mem_wr_ok", 1'b0, ok);
        // slow memory: erase under readout protection clears memory first
        obcd_prog_tool_i.erase_delay = 5;
        cnt = erase_seen;
        bcnt = busy_seen;
        obcd_prog_tool_i.tool_req(3'h2, 1'b0, 8'h00, ok, d);
        check_bit("opt_er_ok", 1'b1, ok);
        check_byte("erase_cnt", 8'(cnt + 1), 8'(erase_seen));
        check_byte("busy_cnt", 8'(bcnt + 8), 8'(busy_seen));
        obcd_prog_tool_i.tool_req(3'h0, 1'b0, 8'h00, ok, d);
        check_byte("prot_byte", 8'hff, d);
        obcd_prog_tool_i.tool_req(3'h0, 1'b1, 8'h00, ok, d);
        check_byte("clk_byte", 8'hff, d);
        // erased protect byte now sets write protection for good
        cnt = erase_seen;
        obcd_prog_tool_i.tool_req(3'h2, 1'b0, 8'h00, ok, d);
        check_bit("opt_er_ok", 1'b0, ok);
        obcd_prog_tool_i.tool_req(3'h3, 1'b0, 8'h00, ok, d);
        check_bit("mem_er_ok", 1'b0, ok);
        obcd_prog_tool_i.tool_req(3'h1, 1'b0, 8'hfe, ok, d);
        check_bit("opt_wr_ok", 1'b0, ok);
        check_byte("erase_cnt", 8'(cnt), 8'(erase_seen));
        obcd_prog_tool_i.tool_req(3'h0, 1'b0, 8'h00, ok, d);
        check_byte("prot_byte", 8'hff, d);
        do_reset(1'b0, 4);
        check_cfg("cfg_erased", {2'h3, 1'b0, 2'h3, 1'b0, 6'h3f}, config_out);
        // factory load, then a plain option erase
        do_reset(1'b1, 20);
        obcd_prog_tool_i.tool_req(3'h2, 1'b0, 8'h00, ok, d);
        check_bit("opt_er_ok", 1'b1, ok);
        obcd_prog_tool_i.tool_req(3'h0, 1'b1, 8'h00, ok, d);
        check_byte("clk_byte", 8'hff, d);
        prog_mode_pin_in = 1'b0;
        repeat (8) @(negedge clk_in);
        obcd_prog_tool_i.tool_req(3'h1, 1'b1, 8'h2f, ok, d);
        check_bit("opt_wr_ok", 1'b0, ok);
        tally_and_finish();
    end
endmodule : tb_obcd_top
